// >>> tb_pkg.sv
package tbu_pkg;

    // ------------------------------------------------------------
    // widths and register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_COUNT   = 4'h1;
    localparam logic [3:0] ADDR_DIVIDER = 4'h2;
    localparam logic [3:0] ADDR_PERIOD  = 4'h3;
    localparam logic [3:0] ADDR_EVENT   = 4'h4;
    localparam logic [3:0] ADDR_STATUS  = 4'h5;
    localparam logic [3:0] ADDR_CLEAR   = 4'h6;
    localparam logic [3:0] ADDR_IRQ_EN  = 4'h7;

    // ------------------------------------------------------------
    // control, event and status register bit positions
    // ------------------------------------------------------------
    localparam int CTL_ENABLE   = 0;
    localparam int CTL_SUPPRESS = 1;
    localparam int CTL_SOURCE   = 2;
    localparam int CTL_SINGLE   = 3;
    localparam int CTL_MODE_LO  = 4;
    localparam int CTL_PRELOAD  = 7;
    localparam int CTL_CKD_LO   = 8;
    localparam int DIV_LOAD_NOW = 0;
    localparam int EV_SW_UPDATE = 0;
    localparam int ST_UPDATE    = 0;
    localparam int ST_OVER      = 1;
    localparam int ST_UNDER     = 2;
    localparam int ST_W         = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] PERIOD_RESET  = 16'hFFFF;
    localparam logic [15:0] DIVIDER_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        count_upward,
        count_downward,
        centre_mode_one,
        centre_mode_two,
        centre_mode_three
    } count_mode_e;

    typedef enum logic [1:0] {
        sample_clock_div_one,
        sample_clock_div_two,
        sample_clock_div_four
    } clock_div_e;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic        counter_enable;
        logic        update_suppress;
        logic        update_source_wrap_only;
        logic        single_shot_select;
        count_mode_e mode;
        logic        period_preload;
        clock_div_e  ckd;
    } ctrl_s;

endpackage

// >>> tb_sample_div.sv
`timescale 1ns/1ps
module tbu_sample_div
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              nrst,
    // division choice
    input  wire tbu_pkg::clock_div_e ckd,
    // one-cycle enable at the sampling rate
    output logic                   dead_time_sample_period
);
    import tbu_pkg::*;

    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic       tick_nxt;

    always_comb
    begin
        cnt_nxt  = cnt_r + 2'h1;
        tick_nxt = 1'b0;
        case (ckd)
            sample_clock_div_two:  tick_nxt = cnt_r[0];
            sample_clock_div_four: tick_nxt = (cnt_r == 2'h3);
            default:               tick_nxt = 1'b1;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            cnt_r                   <= 2'h0;
            dead_time_sample_period <= 1'b0;
        end
        else
        begin
            cnt_r                   <= cnt_nxt;
            dead_time_sample_period <= tick_nxt;
        end
    end
endmodule

// >>> tb_top.sv
// What this block does
// - divider load now or at update
// - divider readback equals divider register
// - up, down, three centre modes
// - count write loads, read returns count
// - period limit is counter wrap value
// - suppress bit blocks update events
// - broad source: wrap, software, slave update
// - wrap-only source: only wrap raises request
// - preload stage before period limit
// - single-shot or free-running operation
// - sample clock period one, two, four
// - enable starts, clearing halts counter
// - reset: FFFF period, divider zero, up
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
module tbu_top
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              nrst,
    // register port
    input  wire tbu_pkg::bus_req_s req,
    output logic [15:0]            rdata,
    // slave mode controller update request
    input  wire logic              slave_update,
    // events and timing
    output logic                   irq,
    output logic                   update_pulse,
    output logic                   dead_time_sample_period
);
    import tbu_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ctrl_s       ctrl_r,     ctrl_nxt;
    logic [15:0] count_r,    count_nxt;
    logic [15:0] div_r,      div_nxt;      // software view
    logic [15:0] div_act_r,  div_act_nxt;
    logic [15:0] div_cnt_r,  div_cnt_nxt;
    logic        div_on_upd_r, div_on_upd_nxt;
    logic [15:0] period_r,   period_nxt;   // software view
    logic [15:0] period_act_r, period_act_nxt;
    logic        down_r,     down_nxt;
    logic [ST_W-1:0] status_r, status_nxt;
    logic [ST_W-1:0] irq_en_r, irq_en_nxt;
    logic [15:0] rdata_nxt;
    logic        upd_nxt;
    logic        irq_nxt;
    logic        slave_s1_r, slave_s2_r;

    logic        tick;
    logic        over;
    logic        under;
    logic        sw_upd;
    logic        update;
    logic        flag_req;
    logic        centre;

    function automatic logic hit(input bus_req_s r, input logic [3:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    always_comb
    begin
        centre       = ctrl_r.mode inside {centre_mode_one, centre_mode_two,
                                           centre_mode_three};
        // at or past the limit: a smaller divider loaded mid-count must not stall a full wrap
        tick         = ctrl_r.counter_enable && (div_cnt_r >= div_act_r);
        over         = 1'b0;
        under        = 1'b0;
        count_nxt    = count_r;
        down_nxt     = down_r;
        div_cnt_nxt  = div_cnt_r;
        if (ctrl_r.counter_enable)
            div_cnt_nxt = tick ? 16'h0000 : div_cnt_r + 16'h0001;
        if (tick)
        begin
            case (ctrl_r.mode)
                count_upward:
                begin
                    over = (count_r >= period_act_r);
                    count_nxt = over ? 16'h0000 : count_r + 16'h0001;
                end
                count_downward:
                begin
                    under = (count_r == 16'h0000);
                    count_nxt = under ? period_act_r : count_r - 16'h0001;
                end
                default:
                begin
                    if (!down_r)
                    begin
                        over = (count_r >= period_act_r - 16'h0001);
                        count_nxt = count_r + 16'h0001;
                        down_nxt = over;
                    end
                    else
                    begin
                        under = (count_r <= 16'h0001);
                        count_nxt = count_r - 16'h0001;
                        down_nxt = !under;
                    end
                end
            endcase
        end
        if (!centre)
            down_nxt = (ctrl_r.mode == count_downward);
        sw_upd   = hit(req, ADDR_EVENT) && req.wdata[EV_SW_UPDATE];
        update   = !ctrl_r.update_suppress
                   && (over || under || sw_upd || slave_s2_r);
        flag_req = !ctrl_r.update_suppress && (over || under
                   || (!ctrl_r.update_source_wrap_only
                       && (sw_upd || slave_s2_r)));
        if (update && (sw_upd || slave_s2_r) && !over && !under)
        begin
            div_cnt_nxt = 16'h0000;
            count_nxt   = (ctrl_r.mode == count_downward) ? period_act_r : 16'h0000;
        end
        if (hit(req, ADDR_COUNT))
            count_nxt = req.wdata;
    end

    // ------------------------------------------------------------
    // registers and shadows
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_nxt       = ctrl_r;
        div_nxt        = div_r;
        div_act_nxt    = div_act_r;
        div_on_upd_nxt = div_on_upd_r;
        period_nxt     = period_r;
        period_act_nxt = period_act_r;
        irq_en_nxt     = irq_en_r;
        status_nxt     = status_r;
        if (update)
        begin
            if (div_on_upd_r)
            begin
                div_act_nxt    = div_r;
                div_on_upd_nxt = 1'b0;
            end
            period_act_nxt = period_r;
            if (ctrl_r.single_shot_select)
                ctrl_nxt.counter_enable = 1'b0;
        end
        if (hit(req, ADDR_CTRL))
        begin
            ctrl_nxt.counter_enable          = req.wdata[CTL_ENABLE];
            ctrl_nxt.update_suppress         = req.wdata[CTL_SUPPRESS];
            ctrl_nxt.update_source_wrap_only = req.wdata[CTL_SOURCE];
            ctrl_nxt.single_shot_select      = req.wdata[CTL_SINGLE];
            ctrl_nxt.mode = count_mode_e'(req.wdata[CTL_MODE_LO +: 3]);
            ctrl_nxt.period_preload          = req.wdata[CTL_PRELOAD];
            ctrl_nxt.ckd  = clock_div_e'(req.wdata[CTL_CKD_LO +: 2]);
        end
        // load mode rides on the event register, bit above the software trigger
        if (hit(req, ADDR_DIVIDER))
            div_nxt = req.wdata;
        if (hit(req, ADDR_EVENT) && req.wdata[DIV_LOAD_NOW + 1])
            div_act_nxt = div_r; // divider_load_now on the held value
        if (hit(req, ADDR_DIVIDER))
            div_on_upd_nxt = 1'b1; // divider_load_on_update by default
        if (hit(req, ADDR_PERIOD))
        begin
            period_nxt = req.wdata;
            if (!ctrl_r.period_preload)
                period_act_nxt = req.wdata;
        end
        if (hit(req, ADDR_IRQ_EN))
            irq_en_nxt = req.wdata[ST_W-1:0];
        if (hit(req, ADDR_CLEAR))
            status_nxt = status_r & ~req.wdata[ST_W-1:0];
        // set wins over a clear in the same cycle
        status_nxt = status_nxt | {under & flag_req, over & flag_req, flag_req};
        irq_nxt    = |(status_nxt & irq_en_nxt);
        upd_nxt    = update;
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_comb
    begin
        rdata_nxt = 16'h0000;
        if (req.rd)
        begin
            if (req.addr == ADDR_CTRL)
                rdata_nxt = {6'h00, ctrl_r.ckd, ctrl_r.period_preload, ctrl_r.mode,
                             ctrl_r.single_shot_select, ctrl_r.update_source_wrap_only,
                             ctrl_r.update_suppress, ctrl_r.counter_enable};
            else if (req.addr == ADDR_COUNT)
                rdata_nxt = count_r;
            else if (req.addr == ADDR_DIVIDER)
                rdata_nxt = div_r;
            else if (req.addr == ADDR_PERIOD)
                rdata_nxt = period_r;
            else if (req.addr == ADDR_STATUS)
                rdata_nxt = {13'h0000, status_r};
            else if (req.addr == ADDR_IRQ_EN)
                rdata_nxt = {13'h0000, irq_en_r};
            else
                rdata_nxt = 16'h0000;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            ctrl_r       <= '{1'b0, 1'b0, 1'b0, 1'b0, count_upward, 1'b0,
                              sample_clock_div_one};
            count_r      <= COUNT_RESET;
            div_r        <= DIVIDER_RESET;
            div_act_r    <= DIVIDER_RESET;
            div_cnt_r    <= 16'h0000;
            div_on_upd_r <= 1'b0;
            period_r     <= PERIOD_RESET;
            period_act_r <= PERIOD_RESET;
            down_r       <= 1'b0;
            status_r     <= '0;
            irq_en_r     <= '0;
            rdata        <= 16'h0000;
            irq          <= 1'b0;
            update_pulse <= 1'b0;
            slave_s1_r   <= 1'b0;
            slave_s2_r   <= 1'b0;
        end
        else
        begin
            ctrl_r       <= ctrl_nxt;
            count_r      <= count_nxt;
            div_r        <= div_nxt;
            div_act_r    <= div_act_nxt;
            div_cnt_r    <= div_cnt_nxt;
            div_on_upd_r <= div_on_upd_nxt;
            period_r     <= period_nxt;
            period_act_r <= period_act_nxt;
            down_r       <= down_nxt;
            status_r     <= status_nxt;
            irq_en_r     <= irq_en_nxt;
            rdata        <= rdata_nxt;
            irq          <= irq_nxt;
            update_pulse <= upd_nxt;
            slave_s1_r   <= slave_update;
            slave_s2_r   <= slave_s1_r;
        end
    end

    // ------------------------------------------------------------
    // sampling clock divider
    // ------------------------------------------------------------
    tbu_sample_div u_sample_div
    (
        .mclk                    (mclk),
        .nrst                    (nrst),
        .ckd                     (ctrl_r.ckd),
        .dead_time_sample_period (dead_time_sample_period)
    );
endmodule

// >>> tbu_top_checker.sv
`timescale 1ns/1ps
module tbu_top_checker
(
    // clock and reset
    input wire logic              mclk,
    input wire logic              nrst,
    // register port
    input wire tbu_pkg::bus_req_s req,
    input wire logic [15:0]       rdata,
    // events and timing
    input wire logic              slave_update,
    input wire logic              irq,
    input wire logic              update_pulse,
    input wire logic              dead_time_sample_period
);
    import tbu_pkg::*;
    // ----------------------------------------
    // shadow of software settings
    // ----------------------------------------
    logic [9:0] ctl_r, ctl_nxt;
    logic [2:0] en_r, en_nxt;
    logic [2:0] stab_r, stab_nxt;
    always_comb
    begin
        ctl_nxt  = ctl_r;
        en_nxt   = en_r;
        stab_nxt = (stab_r == 3'h7) ? stab_r : stab_r + 3'h1;
        if (req.wr && req.addr == ADDR_CTRL)
        begin
            ctl_nxt  = req.wdata[9:0];
            stab_nxt = 3'h0;
        end
        if (req.wr && req.addr == ADDR_IRQ_EN)
            en_nxt = req.wdata[2:0];
    end
    always_ff @(posedge mclk)
    begin
        ctl_r  <= nrst ? ctl_nxt : 10'h000;
        en_r   <= nrst ? en_nxt : 3'h0;
        stab_r <= nrst ? stab_nxt : 3'h0;
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // reset itself is the cause here, so no disable
    property p_reset_quiet;
        disable iff (1'b0) !nrst |=> rdata == 16'h0000 && !irq && !update_pulse
            && !dead_time_sample_period;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs not quiet after reset");
    property p_rd_idle;
        !req.rd |=> rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data without a read");
    property p_suppress;
        ctl_r[CTL_SUPPRESS] && stab_r >= 3'h3 |-> !update_pulse;
    endproperty
    a_suppress: assert property (p_suppress)
        else $error("update while suppressed");
    property p_sw_update;
        req.wr && req.addr == ADDR_EVENT && req.wdata[0] && !ctl_r[CTL_SUPPRESS]
            && stab_r >= 3'h3 |-> ##[1:3] update_pulse;
    endproperty
    a_sw_update: assert property (p_sw_update)
        else $error("software update lost");
    property p_slave_update;
        $rose(slave_update) && !ctl_r[CTL_SUPPRESS] && stab_r >= 3'h3
            |-> ##[2:5] update_pulse;
    endproperty
    a_slave_update: assert property (p_slave_update)
        else $error("slave update lost");
    property p_irq_follows;
        update_pulse && en_r[ST_UPDATE] && !ctl_r[CTL_SOURCE] && !ctl_r[CTL_SUPPRESS]
            && !(req.wr && req.addr == ADDR_CLEAR) |-> ##[0:2] irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("enabled update raised no interrupt");
    property p_irq_masked;
        en_r == 3'h0 && $past(en_r) == 3'h0 |-> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt with all sources masked");
    property p_div_one;
        ctl_r[9:8] == 2'h0 && stab_r >= 3'h4 |-> dead_time_sample_period;
    endproperty
    a_div_one: assert property (p_div_one)
        else $error("sample enable gap at division one");
    property p_div_two;
        ctl_r[9:8] == 2'h1 && stab_r >= 3'h4 && dead_time_sample_period
            |=> !dead_time_sample_period;
    endproperty
    a_div_two: assert property (p_div_two)
        else $error("sample enable too dense at division two");
    c_update: cover property (update_pulse);
    c_irq: cover property (irq);
    c_div_four: cover property (ctl_r[9:8] == 2'h2 && dead_time_sample_period);
endmodule

// >>> tbu_top_tb.sv
`timescale 1ns/1ps
module tbu_top_tb;
    import tbu_pkg::*;
    logic             mclk = 1'b0;
    logic             nrst;
    bus_req_s         req;
    logic [15:0]      rdata;
    logic             slave_update;
    logic             irq;
    logic             update_pulse;
    logic             dtsp;
    int               n_errors = 0;
    int               checks = 0;
    always #5 mclk = ~mclk;
    tbu_top uut (.mclk(mclk), .nrst(nrst), .req(req), .rdata(rdata),
        .slave_update(slave_update), .irq(irq), .update_pulse(update_pulse),
        .dead_time_sample_period(dtsp));
    // ----------------------------------------
    // bus tasks and compare
    // ----------------------------------------
    // one idle cycle after each access keeps the request from being written twice
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge mclk);
        req <= '0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge mclk);
        req <= '0;
        @(negedge mclk);
        v = rdata;
        @(posedge mclk);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] e, input string nm);
        logic [15:0] v;
        rd(a, v);
        chk(nm, e, v);
    endtask
    // cycles up to and including the next update pulse
    task automatic gap(output int n);
        n = 0;
        do
        begin
            @(negedge mclk);
            n++;
        end
        while (update_pulse !== 1'b1 && n < 400);
        @(posedge mclk);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        logic [15:0] v;
        int n;
        req = '0;
        slave_update = 1'b0;
        nrst = 1'b0;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        rc(ADDR_CTRL, 16'h0000, "ctrl reset");
        rc(ADDR_PERIOD, 16'hFFFF, "period reset");
        rc(ADDR_DIVIDER, 16'h0000, "divider reset");
        rc(4'hF, 16'h0000, "unmapped read");
        wr(ADDR_COUNT, 16'h1234);
        rc(ADDR_COUNT, 16'h1234, "count load");
        wr(ADDR_CTRL, 16'h0001);
        wr(ADDR_CTRL, 16'h0000);
        rd(ADDR_COUNT, v);
        chk("count ran", 16'h0001, 16'(v > 16'h1234));
        wr(ADDR_COUNT, 16'h0100);
        repeat (5) @(posedge mclk);
        rc(ADDR_COUNT, 16'h0100, "count halted");
        $display("end of basic");
        wr(ADDR_COUNT, 16'h0000);
        wr(ADDR_PERIOD, 16'h0005);
        wr(ADDR_IRQ_EN, 16'h0007);
        wr(ADDR_CTRL, 16'h0001);
        gap(n);
        gap(n);
        chk("wrap gap", 16'h0006, 16'(n));
        wr(ADDR_CTRL, 16'h0000);
        rc(ADDR_STATUS, 16'h0003, "wrap status");
        chk("irq high", 16'h0001, {15'h0, irq});
        wr(ADDR_CLEAR, 16'h0007);
        rc(ADDR_STATUS, 16'h0000, "cleared");
        chk("irq low", 16'h0000, {15'h0, irq});
        $display("end of wrap");
        wr(ADDR_DIVIDER, 16'h0001);
        rc(ADDR_DIVIDER, 16'h0001, "divider read");
        wr(ADDR_COUNT, 16'h0000);
        wr(ADDR_CTRL, 16'h0001);
        gap(n);
        wr(ADDR_DIVIDER, 16'h0002);
        gap(n);
        chk("old divider", 16'h000C, 16'(n + 2));
        gap(n);
        chk("new divider", 16'h0012, 16'(n));
        wr(ADDR_DIVIDER, 16'h0000);
        wr(ADDR_EVENT, 16'h0002);
        gap(n);
        chk("load now", 16'h0001, 16'(n + 4 < 18));
        wr(ADDR_CTRL, 16'h0000);
        $display("end of divider");
        for (int k = 0; k < 2; k++)
        begin
            wr(ADDR_COUNT, 16'h0000);
            wr(ADDR_PERIOD, 16'h0005);
            wr(ADDR_CTRL, k ? 16'h0081 : 16'h0001);
            gap(n);
            wr(ADDR_PERIOD, 16'h0009);
            gap(n);
            chk("period apply", k ? 16'h0006 : 16'h000A, 16'(n + 2));
            rc(ADDR_PERIOD, 16'h0009, "period read");
            wr(ADDR_CTRL, 16'h0000);
        end
        $display("end of preload");
        wr(ADDR_COUNT, 16'h0000);
        wr(ADDR_PERIOD, 16'h0003);
        wr(ADDR_CTRL, 16'h0009);
        gap(n);
        repeat (3) @(posedge mclk);
        rc(ADDR_CTRL, 16'h0008, "single shot stop");
        rc(ADDR_COUNT, 16'h0000, "single shot count");
        $display("end of single shot");
        // wrap-only source must hide software and slave updates from status
        for (int k = 0; k < 4; k++)
        begin
            wr(ADDR_CLEAR, 16'h0007);
            wr(ADDR_CTRL, k[1] ? 16'h0004 : 16'h0000);
            wr(ADDR_COUNT, 16'h0055);
            if (k[0])
            begin
                slave_update <= 1'b1;
                @(posedge mclk);
                slave_update <= 1'b0;
                repeat (6) @(posedge mclk);
            end
            else
                wr(ADDR_EVENT, 16'h0001);
            rc(ADDR_STATUS, k[1] ? 16'h0000 : 16'h0001, "update source");
            rc(ADDR_COUNT, 16'h0000, "update reinit");
        end
        $display("end of sources");
        wr(ADDR_CLEAR, 16'h0007);
        wr(ADDR_COUNT, 16'h0000);
        wr(ADDR_CTRL, 16'h0003);
        repeat (30) @(posedge mclk);
        wr(ADDR_EVENT, 16'h0001);
        rc(ADDR_STATUS, 16'h0000, "suppressed");
        wr(ADDR_CTRL, 16'h0001);
        gap(n);
        chk("resumed", 16'h0001, 16'(n < 10));
        wr(ADDR_CTRL, 16'h0000);
        $display("end of suppress");
        for (int k = 1; k < 5; k++)
        begin
            rc(ADDR_CTRL, 16'h0000, "mode pre");
            wr(ADDR_CTRL, 16'(k << 4));
            rc(ADDR_CTRL, 16'(k << 4), "mode");
            wr(ADDR_CTRL, 16'h0000);
        end
        wr(ADDR_CLEAR, 16'h0007);
        wr(ADDR_PERIOD, 16'h0004);
        wr(ADDR_COUNT, 16'h0002);
        wr(ADDR_CTRL, 16'h0011);
        gap(n);
        wr(ADDR_CTRL, 16'h0000);
        rd(ADDR_STATUS, v);
        chk("underflow", 16'h0004, v & 16'h0004);
        // centre counting: up to the limit and back, one event at each turn
        wr(ADDR_CLEAR, 16'h0007);
        wr(ADDR_COUNT, 16'h0000);
        wr(ADDR_CTRL, 16'h0021);
        gap(n);
        gap(n);
        wr(ADDR_CTRL, 16'h0000);
        chk("centre half period", 16'h0004, 16'(n));
        rc(ADDR_STATUS, 16'h0007, "centre flags");
        $display("end of modes");
        for (int k = 0; k < 3; k++)
        begin
            wr(ADDR_CTRL, 16'(k << 8));
            n = 0;
            repeat (40)
            begin
                @(negedge mclk);
                n += dtsp;
            end
            @(posedge mclk);
            chk("sample rate", 16'(40 >> k), 16'(n));
        end
        $display("end of sample clock");
        close_out();
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        close_out();
    end
endmodule
bind tbu_top tbu_top_checker chk_i (.mclk(mclk), .nrst(nrst), .req(req), .rdata(rdata),
    .slave_update(slave_update), .irq(irq), .update_pulse(update_pulse),
    .dead_time_sample_period(dead_time_sample_period));
